// ==== rtl/rfst_pkg.sv ====
// Constants for the receive frame status and transmit enqueue block.
// Assumes a 16-bit register port with byte enables and an 8-bit byte address.
package rfst_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] RX_FRAME_HEADER_STATUS_OFS = 8'h7c;
  localparam logic [7:0] RX_FRAME_BYTE_COUNT_OFS = 8'h7e;
  localparam logic [7:0] TX_QUEUE_COMMAND_OFS = 8'h80;

  // ==========================================================================
  // Header status field positions
  localparam int RX_FRAME_VALID_BIT = 15;
  localparam int ICMP_CHECKSUM_BAD_BIT = 13;
  localparam int IP_HEADER_CHECKSUM_BAD_BIT = 12;
  localparam int TCP_CHECKSUM_BAD_BIT = 11;
  localparam int UDP_CHECKSUM_BAD_BIT = 10;
  localparam int BROADCAST_FLAG_BIT = 7;
  localparam int MULTICAST_FLAG_BIT = 6;
  localparam int UNICAST_FLAG_BIT = 5;
  localparam int MII_SYMBOL_ERROR_BIT = 4;
  localparam int ETHERTYPE_FRAME_BIT = 3;
  localparam int FRAME_TOO_LONG_BIT = 2;
  localparam int RUNT_FRAME_BIT = 1;
  localparam int CRC_ERROR_BIT = 0;

  // ==========================================================================
  // Byte count and command fields
  localparam int RX_BYTE_SIZE_W = 12;
  localparam int MANUAL_ENQUEUE_BIT = 0;
  localparam int FREE_MEMORY_MONITOR_BIT = 1;
  localparam int AUTO_ENQUEUE_BIT = 2;
  localparam int TX_CMD_CTRL_W = 3;
  localparam int TX_MEM_W = 13;
  localparam logic [15:0] TX_QUEUE_COMMAND_RESET = 16'h0000;

  // ==========================================================================
  // Frame length limits in bytes
  localparam logic [15:0] ETHERTYPE_MIN_EXCLUSIVE = 16'h05dc;
  localparam logic [11:0] FRAME_LEN_MAX = 12'h7d0;

endpackage : rfst_pkg

// ==== rtl/rfst_tx_if.sv ====
// Carries the transmit command bits between the register front end and the enqueue engine.
// Assumes both ends share core_clk.
interface rfst_tx_if;
  logic cmd_wr;
  logic [rfst_pkg::TX_CMD_CTRL_W-1:0] cmd_wdata;
  logic [rfst_pkg::TX_CMD_CTRL_W-1:0] cmd_bits;

  modport ctrl (
    output cmd_wr,
    output cmd_wdata,
    input cmd_bits
  );

  modport engine (
    input cmd_wr,
    input cmd_wdata,
    output cmd_bits
  );
endinterface : rfst_tx_if

// ==== rtl/rfst_rx_classify.sv ====
// Builds the header status word and keep decision for one finished receive frame.
// Assumes all inputs are stable in the cycle that frame_done is high.
module rfst_rx_classify (
  // Frame facts from the receive MAC
  input wire logic [47:0] dest_addr,
  input wire logic [15:0] len_type,
  input wire logic [rfst_pkg::RX_BYTE_SIZE_W-1:0] byte_count,
  input wire logic icmp_bad,
  input wire logic ip_bad,
  input wire logic tcp_bad,
  input wire logic udp_bad,
  input wire logic mii_error,
  input wire logic collision,
  input wire logic early_end,
  input wire logic crc_error,
  input wire logic pass_bad_frame,
  // Result
  output logic [15:0] status,
  output logic keep
);
  logic is_bcast;
  logic is_mcast;
  logic is_runt;
  logic too_long;

  // ==========================================================================
  // Classification
  // address class
  assign is_bcast = &dest_addr;
  assign is_mcast = dest_addr[40];
  assign is_runt = collision | early_end;
  assign too_long = byte_count > rfst_pkg::FRAME_LEN_MAX;

  always_comb begin
    status = 16'h0000;
    status[rfst_pkg::ICMP_CHECKSUM_BAD_BIT] = icmp_bad;
    status[rfst_pkg::IP_HEADER_CHECKSUM_BAD_BIT] = ip_bad;
    status[rfst_pkg::TCP_CHECKSUM_BAD_BIT] = tcp_bad;
    status[rfst_pkg::UDP_CHECKSUM_BAD_BIT] = udp_bad;
    status[rfst_pkg::BROADCAST_FLAG_BIT] = is_bcast;
    status[rfst_pkg::MULTICAST_FLAG_BIT] = is_mcast;
    status[rfst_pkg::UNICAST_FLAG_BIT] = ~is_mcast;
    status[rfst_pkg::MII_SYMBOL_ERROR_BIT] = mii_error;
    // type versus length, held low on runts since it means nothing there
    status[rfst_pkg::ETHERTYPE_FRAME_BIT] = ~is_runt & (len_type > rfst_pkg::ETHERTYPE_MIN_EXCLUSIVE);
    // too long flag only, no truncation
    status[rfst_pkg::FRAME_TOO_LONG_BIT] = too_long;
    status[rfst_pkg::RUNT_FRAME_BIT] = is_runt;
    status[rfst_pkg::CRC_ERROR_BIT] = crc_error;
  end

  // bad frames kept only when passing is enabled
  assign keep = pass_bad_frame | ~(too_long | is_runt | crc_error);

endmodule : rfst_rx_classify

// ==== rtl/rfst_tx_enqueue.sv ====
// Transmit enqueue engine: manual and automatic enqueue and the free memory monitor.
// Assumes frame events arrive as one-cycle pulses on core_clk.
module rfst_tx_enqueue (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Command bits
  rfst_tx_if.engine cmd,
  // Transmit queue side
  input wire logic frame_prepared,
  input wire logic frame_done,
  input wire logic [rfst_pkg::TX_MEM_W-1:0] free_bytes,
  input wire logic [rfst_pkg::TX_MEM_W-1:0] size_request,
  output logic enqueue,
  output logic mem_avail_event
);
  logic manual_q;
  logic monitor_q;
  logic auto_q;
  logic fired_q;
  logic enqueue_q;
  logic event_q;
  logic manual_set;
  logic monitor_set;

  assign manual_set = cmd.cmd_wr & cmd.cmd_wdata[rfst_pkg::MANUAL_ENQUEUE_BIT];
  assign monitor_set = cmd.cmd_wr & cmd.cmd_wdata[rfst_pkg::FREE_MEMORY_MONITOR_BIT];

  // ==========================================================================
  // Manual enqueue
  always_ff @(posedge core_clk) begin
    if (reset) begin
      manual_q <= 1'b0;
    end else if (clk_en) begin
      if (manual_set) begin
        manual_q <= 1'b1;
      end else if (frame_done) begin
        manual_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Automatic enqueue
  always_ff @(posedge core_clk) begin
    if (reset) begin
      auto_q <= 1'b0;
    end else if (clk_en && cmd.cmd_wr) begin
      auto_q <= cmd.cmd_wdata[rfst_pkg::AUTO_ENQUEUE_BIT];
    end
  end

  // ==========================================================================
  // Enqueue pulse
  always_ff @(posedge core_clk) begin
    if (reset) begin
      enqueue_q <= 1'b0;
    end else if (clk_en) begin
      // one frame per manual write while bit 0 is clear, every prepared frame in auto
      enqueue_q <= (manual_set & ~manual_q) | (auto_q & frame_prepared);
    end
  end

  // ==========================================================================
  // Free memory monitor
  always_ff @(posedge core_clk) begin
    if (reset) begin
      monitor_q <= 1'b0;
    end else if (clk_en) begin
      // self-clear after the frame, set wins
      if (monitor_set) begin
        monitor_q <= 1'b1;
      end else if (frame_done) begin
        monitor_q <= 1'b0;
      end
    end
  end

  // One event per arming; rearms only after the self-clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fired_q <= 1'b0;
      event_q <= 1'b0;
    end else if (clk_en) begin
      event_q <= monitor_q & ~fired_q & (free_bytes >= size_request);
      if (!monitor_q) begin
        fired_q <= 1'b0;
      end else if (free_bytes >= size_request) begin
        fired_q <= 1'b1;
      end
    end
  end

  assign cmd.cmd_bits = {auto_q, monitor_q, manual_q};
  assign enqueue = enqueue_q;
  assign mem_avail_event = event_q;

endmodule : rfst_tx_enqueue

// ==== rtl/rfst_top.sv ====
// Receive frame status queue and transmit queue command registers.
// Assumes a same-clock register port fed by the SPI front end and a MAC on core_clk.
// Function
// - One status entry per kept received frame while the queue has room, readable while frames are counted.
// - Bit 15 set when head frame and status valid, else clear.
// - Bit 13 flags a bad ICMP checksum.
// - Bits 12, 11, 10 flag bad IP header, TCP and UDP checksums.
// - Bits 7, 6, 5 give broadcast, multicast (incl. broadcast) and unicast.
// - Bit 4 flags an MII symbol error during reception.
// - Bit 3 set for type field above 1500, meaningless for runts.
// - Bit 2 for frames over 2000 bytes; kept only if passing bad frames.
// - Bit 1 for collision-damaged or early-ended runts; kept only if passing bad.
// - Bit 0 for CRC errors; such frames kept only if passing bad.
// - Byte count register bits 11-0 give the current frame size.
// - Command bit 0 queues one frame, self-clears when it has been sent.
// - Command bit 2 queues every prepared frame automatically.
// - Command bit 1 pulses tx_mem_avail_event once free memory meets request.
// - Bit 1 self-clears after the frame is sent; host waits before rearming.
module rfst_top #(
  parameter int RXQ_DEPTH = 8,
  parameter int RXQ_AW = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Receive MAC side
  input wire logic rx_frame_done,
  input wire logic [47:0] rx_dest_addr,
  input wire logic [15:0] rx_len_type,
  input wire logic [rfst_pkg::RX_BYTE_SIZE_W-1:0] rx_byte_size,
  input wire logic rx_icmp_bad,
  input wire logic rx_ip_bad,
  input wire logic rx_tcp_bad,
  input wire logic rx_udp_bad,
  input wire logic rx_mii_error,
  input wire logic rx_collision,
  input wire logic rx_early_end,
  input wire logic rx_crc_error,
  input wire logic pass_bad_frame,
  // Receive queue control
  input wire logic rx_release,
  output logic [RXQ_AW:0] rx_frame_counter,
  output logic rx_overflow,
  // Transmit queue side
  input wire logic tx_frame_prepared,
  input wire logic tx_frame_done,
  input wire logic [rfst_pkg::TX_MEM_W-1:0] tx_free_bytes,
  input wire logic [rfst_pkg::TX_MEM_W-1:0] tx_next_frame_size_request,
  output logic tx_enqueue,
  output logic tx_mem_avail_event
);
  logic [15:0] cls_status;
  logic cls_keep;
  logic [15:0] stat_mem_q [RXQ_DEPTH];
  logic [rfst_pkg::RX_BYTE_SIZE_W-1:0] size_mem_q [RXQ_DEPTH];
  logic [RXQ_AW-1:0] wr_ptr_q;
  logic [RXQ_AW-1:0] rd_ptr_q;
  logic [RXQ_AW:0] count_q;
  logic push;
  logic pop;
  logic full;
  logic overflow_q;
  logic [15:0] head_status;
  logic [15:0] head_size;
  logic [12:0] cmd_reserved_q;
  logic [15:0] cmd_read;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic sel_cmd;

  rfst_tx_if tx_bus ();

  // ==========================================================================
  // Frame classification
  rfst_rx_classify u_classify (
    .dest_addr(rx_dest_addr),
    .len_type(rx_len_type),
    .byte_count(rx_byte_size),
    .icmp_bad(rx_icmp_bad),
    .ip_bad(rx_ip_bad),
    .tcp_bad(rx_tcp_bad),
    .udp_bad(rx_udp_bad),
    .mii_error(rx_mii_error),
    .collision(rx_collision),
    .early_end(rx_early_end),
    .crc_error(rx_crc_error),
    .pass_bad_frame(pass_bad_frame),
    .status(cls_status),
    .keep(cls_keep)
  );

  // ==========================================================================
  // Receive status queue
  assign full = count_q == (RXQ_AW + 1)'(RXQ_DEPTH);
  assign push = rx_frame_done & cls_keep & ~full;
  // release advances to the next frame
  assign pop = rx_release & (count_q != '0);

  // Entries written in place; the pointer picks the slot
  always_ff @(posedge core_clk) begin
    if (clk_en && push) begin
      stat_mem_q[wr_ptr_q] <= cls_status;
      size_mem_q[wr_ptr_q] <= rx_byte_size;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
    end else if (clk_en && push) begin
      wr_ptr_q <= (wr_ptr_q == RXQ_AW'(RXQ_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_ptr_q <= '0;
    end else if (clk_en && pop) begin
      rd_ptr_q <= (rd_ptr_q == RXQ_AW'(RXQ_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_q <= '0;
    end else if (clk_en) begin
      // Simultaneous push and pop leave the count alone
      unique case ({push, pop})
        2'b10: begin
          count_q <= count_q + 1'b1;
        end
        2'b01: begin
          count_q <= count_q - 1'b1;
        end
        2'b00, 2'b11: begin
          count_q <= count_q;
        end
      endcase
    end
  end

  // A full queue cannot grow, so a kept frame arriving then is lost and flagged
  always_ff @(posedge core_clk) begin
    if (reset) begin
      overflow_q <= 1'b0;
    end else if (clk_en) begin
      overflow_q <= rx_frame_done & cls_keep & full;
    end
  end

  // ==========================================================================
  // Head entry view
  always_comb begin
    head_status = 16'h0000;
    head_size = 16'h0000;
    if (count_q != '0) begin
      head_status = stat_mem_q[rd_ptr_q];
      // valid only with a pending completed frame
      head_status[rfst_pkg::RX_FRAME_VALID_BIT] = 1'b1;
      // twelve bit size, upper bits zero
      head_size[rfst_pkg::RX_BYTE_SIZE_W-1:0] = size_mem_q[rd_ptr_q];
    end
  end

  // ==========================================================================
  // Transmit command register
  assign sel_cmd = reg_addr == rfst_pkg::TX_QUEUE_COMMAND_OFS;
  assign tx_bus.cmd_wr = clk_en & reg_wr & sel_cmd & reg_be[0];
  assign tx_bus.cmd_wdata = reg_wdata[rfst_pkg::TX_CMD_CTRL_W-1:0];

  // Reserved upper bits are plain storage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_reserved_q <= rfst_pkg::TX_QUEUE_COMMAND_RESET[15:3];
    end else if (clk_en && reg_wr && sel_cmd) begin
      if (reg_be[0]) begin
        cmd_reserved_q[4:0] <= reg_wdata[7:3];
      end
      if (reg_be[1]) begin
        cmd_reserved_q[12:5] <= reg_wdata[15:8];
      end
    end
  end

  assign cmd_read = {cmd_reserved_q, tx_bus.cmd_bits};

  rfst_tx_enqueue u_tx_enqueue (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .cmd(tx_bus.engine),
    .frame_prepared(tx_frame_prepared),
    .frame_done(tx_frame_done),
    .free_bytes(tx_free_bytes),
    .size_request(tx_next_frame_size_request),
    .enqueue(tx_enqueue),
    .mem_avail_event(tx_mem_avail_event)
  );

  // ==========================================================================
  // Register read
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else if (clk_en) begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        // reads do not consume the entry
        unique case (reg_addr)
          rfst_pkg::RX_FRAME_HEADER_STATUS_OFS: begin
            rdata_q <= head_status;
          end
          rfst_pkg::RX_FRAME_BYTE_COUNT_OFS: begin
            rdata_q <= head_size;
          end
          rfst_pkg::TX_QUEUE_COMMAND_OFS: begin
            rdata_q <= cmd_read;
          end
          default: begin
            rdata_q <= 16'h0000;
          end
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign rx_frame_counter = count_q;
  assign rx_overflow = overflow_q;

endmodule : rfst_top

// ==== sim/rfst_tx_partner.sv ====
// Behavioural transmit queue that finishes each queued frame a fixed time later.
// Assumes core_clk; drives its output at the falling edge, as the bench does.
module rfst_tx_partner #(
  parameter int DELAY = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Queue handshake
  input wire logic tx_enqueue,
  output logic tx_frame_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DELAY-1:0] pipe_q = '0;
  initial tx_frame_done = 1'b0;
  // ========
  // Transmit timing
  // frame completes later
  always @(negedge core_clk) begin
    pipe_q <= reset ? '0 : {pipe_q[DELAY-2:0], tx_enqueue === 1'b1};
    tx_frame_done <= pipe_q[DELAY-1];
  end
endmodule : rfst_tx_partner

// ==== sim/rfst_top_properties.sv ====
// Port-level checks for the frame status and transmit command registers.
// Assumes one core_clk domain with a synchronous reset.
module rfst_top_properties #(
  parameter int RXQ_AW = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // Queues
  input wire logic rx_frame_done,
  input wire logic rx_release,
  input wire logic [RXQ_AW:0] rx_frame_counter,
  input wire logic tx_frame_prepared,
  input wire logic [rfst_pkg::TX_MEM_W-1:0] tx_free_bytes,
  input wire logic [rfst_pkg::TX_MEM_W-1:0] tx_next_frame_size_request,
  input wire logic tx_enqueue,
  input wire logic tx_mem_avail_event
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ========
  // Sequences
  sequence s_rd(logic [7:0] a);
    reg_rd && clk_en && reg_addr == a;
  endsequence
  sequence s_cmd(int b);
    reg_wr && clk_en && reg_addr == 8'h80 && reg_be[0] && reg_wdata[b];
  endsequence
  // ========
  // Assertions
  a_rvalid_follows: assert property (reg_rd && clk_en |=> reg_rvalid)
    else $error("read gave no rvalid");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd && clk_en))
    else $error("rvalid without read");
  a_empty_zero: assert property (s_rd(8'h7c) and rx_frame_counter == 0 |=> reg_rdata == 16'h0000)
    else $error("status not zero when empty");
  a_valid_set: assert property (s_rd(8'h7c) and rx_frame_counter != 0 && !rx_release |=> reg_rdata[15])
    else $error("valid bit clear with frame pending");
  a_count_top_zero: assert property (s_rd(8'h7e) |=> reg_rdata[15:12] == 4'h0)
    else $error("byte count upper bits set");
  a_release_pops: assert property (rx_release && clk_en && !rx_frame_done && rx_frame_counter != 0
    |=> rx_frame_counter == $past(rx_frame_counter) - 1'b1)
    else $error("release did not pop");
  a_enqueue_cause: assert property (tx_enqueue |-> $past((reg_wr && reg_addr == 8'h80 && reg_be[0]
    && reg_wdata[0]) || tx_frame_prepared))
    else $error("enqueue without cause");
  a_monitor_now: assert property (s_cmd(1) and tx_free_bytes >= tx_next_frame_size_request
    |-> ##2 tx_mem_avail_event)
    else $error("monitor event late");
  a_event_cause: assert property (tx_mem_avail_event |-> $past(tx_free_bytes >= tx_next_frame_size_request))
    else $error("event without free space");
endmodule : rfst_top_properties

bind rfst_top rfst_top_properties #(.RXQ_AW(RXQ_AW)) u_props (.core_clk, .reset, .clk_en, .reg_addr,
  .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata, .reg_rvalid, .rx_frame_done, .rx_release,
  .rx_frame_counter, .tx_frame_prepared, .tx_free_bytes, .tx_next_frame_size_request, .tx_enqueue,
  .tx_mem_avail_event);

// ==== sim/rfst_top_test.sv ====
// Register-level bench for receive status and transmit enqueue.
// Assumes the transmit partner model; clk_en is held high except during the freeze test.
module rfst_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, reg_rvalid, rx_done = 0;
  logic pass_bad = 0, rx_release = 0, tx_prep = 0, tx_frame_done, tx_enqueue, tx_evt, ovf;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] fl = 8'h00;
  logic [1:0] reg_be = 2'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_q, len_type = 16'h0000;
  logic [47:0] dest = 48'h0;
  logic [11:0] size = 12'h000;
  logic [3:0] rx_frame_counter;
  logic [12:0] free_b = 13'h0000, req_b = 13'h0000;
  int bad_count = 0, total_checks = 0, enq_n = 0, evt_n = 0, ovf_n = 0;
  // Frame table: bcast at 2000 bytes, mcast too long, runt with crc, crc dropped
  logic [47:0] t_da [4] = '{48'hffffffffffff, 48'h01005e000001, 48'h001122334455, 48'h001122334466};
  logic [15:0] t_lt [4] = '{16'h0800, 16'h05dc, 16'h05dd, 16'h0806};
  logic [11:0] t_sz [4] = '{12'h7d0, 12'h7d1, 12'h03c, 12'h040};
  logic [7:0] t_f [4] = '{8'hf0, 8'h08, 8'h07, 8'h01};
  logic t_p [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  rfst_top dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rx_frame_done(rx_done), .rx_dest_addr(dest), .rx_len_type(len_type), .rx_byte_size(size),
    .rx_icmp_bad(fl[7]), .rx_ip_bad(fl[6]), .rx_tcp_bad(fl[5]), .rx_udp_bad(fl[4]), .rx_mii_error(fl[3]),
    .rx_collision(fl[2]), .rx_early_end(fl[1]), .rx_crc_error(fl[0]), .pass_bad_frame(pass_bad),
    .rx_release(rx_release), .rx_frame_counter(rx_frame_counter), .rx_overflow(ovf),
    .tx_frame_prepared(tx_prep), .tx_frame_done(tx_frame_done), .tx_free_bytes(free_b),
    .tx_next_frame_size_request(req_b), .tx_enqueue(tx_enqueue), .tx_mem_avail_event(tx_evt));
  rfst_tx_partner u_tx (.core_clk(core_clk), .reset(reset), .tx_enqueue(tx_enqueue),
    .tx_frame_done(tx_frame_done));

  initial forever #12.5 core_clk = ~core_clk;
  // Pulses are counted mid-cycle, well away from the edge that launches them
  always @(negedge core_clk) begin
    if (tx_enqueue === 1'b1) enq_n++;
    if (tx_evt === 1'b1) evt_n++;
    if (ovf === 1'b1) ovf_n++;
  end
  // ========
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_be = be;
    reg_wr = 1;
    @(negedge core_clk);
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge core_clk);
    reg_rd = 0;
    chk({15'h0, reg_rvalid}, 16'h0001);
    rd_q = reg_rdata;
  endtask : rd
  // Host polls until the self-clearing bits drop, bounded
  task automatic wait_clear;
    int n;
    n = 0;
    rd(8'h80);
    while (rd_q[1:0] !== 2'b00 && n < 40) begin
      rd(8'h80);
      n++;
    end
    chk(rd_q, 16'h0000);
  endtask : wait_clear
  function automatic logic [15:0] exp_st(input int i);
    logic runt;
    runt = t_f[i][2] | t_f[i][1];
    return {2'b10, t_f[i][7:4], 2'b00, t_da[i] == 48'hffffffffffff, t_da[i][40], !t_da[i][40], t_f[i][3],
      (t_lt[i] > 16'h05dc) & !runt, t_sz[i] > 12'h7d0, runt, t_f[i][0]};
  endfunction : exp_st
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // ========
  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    #(25 * 3000);
    bad_count++;
    finish_test();
  end
  // ========
  // Tests
  initial begin
    tick(10);
    reset = 0;
    rd(8'h80);
    chk(rd_q, 16'h0000);
    rd(8'h7c);
    chk(rd_q, 16'h0000);
    rd(8'h7a);
    chk(rd_q, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      {dest, len_type, size, fl, pass_bad, rx_done} = {t_da[i], t_lt[i], t_sz[i], t_f[i], t_p[i], 1'b1};
      @(negedge core_clk);
      rx_done = 0;
    end
    chk({12'h0, rx_frame_counter}, 16'h0003);
    wr(8'h7c, 16'hffff, 2'h3);
    for (int i = 0; i < 3; i++) begin
      repeat (2) begin
        rd(8'h7c);
        chk(rd_q, exp_st(i));
      end
      rd(8'h7e);
      chk(rd_q, {4'h0, t_sz[i]});
      @(negedge core_clk);
      rx_release = 1;
      @(negedge core_clk);
      rx_release = 0;
      chk({12'h0, rx_frame_counter}, 16'(2 - i));
    end
    rd(8'h7c);
    chk(rd_q, 16'h0000);
    // Nine kept frames into eight slots: the last one is lost and flagged
    pass_bad = 1;
    repeat (9) begin
      @(negedge core_clk);
      rx_done = 1;
      @(negedge core_clk);
      rx_done = 0;
    end
    tick(1);
    chk(16'(ovf_n), 16'h0001);
    chk({12'h0, rx_frame_counter}, 16'h0008);
    repeat (8) begin
      @(negedge core_clk);
      rx_release = 1;
    end
    @(negedge core_clk);
    rx_release = 0;
    chk({12'h0, rx_frame_counter}, 16'h0000);
    $display("test receive done");
    wr(8'h80, 16'h0001, 2'h2);
    tick(3);
    chk(16'(enq_n), 16'h0000);
    wr(8'h80, 16'h0001, 2'h1);
    tick(2);
    chk(16'(enq_n), 16'h0001);
    rd(8'h80);
    chk(rd_q, 16'h0001);
    wr(8'h80, 16'h0001, 2'h1);
    wait_clear();
    chk(16'(enq_n), 16'h0001);
    $display("test manual done");
    wr(8'h80, 16'h0004, 2'h1);
    repeat (2) begin
      @(negedge core_clk);
      tx_prep = 1;
      @(negedge core_clk);
      tx_prep = 0;
    end
    tick(3);
    chk(16'(enq_n), 16'h0003);
    rd(8'h80);
    chk(rd_q, 16'h0004);
    wr(8'h80, 16'h0000, 2'h1);
    tick(12);
    $display("test auto done");
    free_b = 13'd100;
    req_b = 13'd200;
    wr(8'h80, 16'h0002, 2'h1);
    tick(5);
    chk(16'(evt_n), 16'h0000);
    free_b = 13'd300;
    tick(3);
    chk(16'(evt_n), 16'h0001);
    rd(8'h80);
    chk(rd_q, 16'h0002);
    wr(8'h80, 16'h0001, 2'h1);
    wait_clear();
    wr(8'h80, 16'h0002, 2'h1);
    tick(3);
    chk(16'(evt_n), 16'h0002);
    wr(8'h80, 16'h0001, 2'h1);
    wait_clear();
    $display("test monitor done");
    // A write while clk_en is low must leave no trace; let rvalid drop first
    tick(1);
    clk_en = 0;
    wr(8'h80, 16'h0003, 2'h1);
    clk_en = 1;
    tick(2);
    chk(16'(enq_n), 16'h0005);
    rd(8'h80);
    chk(rd_q, 16'h0000);
    $display("test freeze done");
    finish_test();
  end
endmodule : rfst_top_test
